/* File: uart_support_pkg.sv */
// Constants, carrier types and power state encoding of the UART support channel
// Functional notes
// RL1 - Rank seven interrupt kinds; identification reads 00 0001 when none pending.
// RL2 - Line status interrupt is priority 1, code 00 0110.
// RL3 - Receive data interrupt is priority 2, code 00 0100, by level or ready.
// RL4 - Receive time-out interrupt is priority 3, code 00 1100.
// RL5 - Transmit room interrupt is priority 4, code 00 0010.
// RL6 - Modem status interrupt is priority 5, code 00 0000, from status bits 0-3.
// RL7 - Xoff or special character detection raises priority 6, code 01 0000.
// RL8 - Flow pin going low to high under auto flow gives priority 7, code 10 0000.
// RL9 - Line interrupt comes from line status bits 1,2,3,4,7; bit 7 tracks errored entries.
// RL10 - Line status bits 4:2 describe head character, zero when receive queue empty.
// RL11 - Line interrupt clears when errors drained, or overrun by line status read.
// RL12 - Receive data clears below trigger; time-out clears on receive holding read.
// RL13 - Transmit clears on status read or holding write; modem and pin on modem read.
// RL14 - Xoff clears on Xon or status read; special on status read or next character.
// RL15 - Interrupt output works only while some low interrupt-enable bit is set.
// RL16 - Sleep allowed only with enhanced-functions bit 4 and enable bit 4 set.
// RL17 - Enter sleep only when idle, empty, quiet, key 0xFF, no non-transmit interrupt.
// RL18 - Wake on receive line change, modem input change or transmit write.
// RL19 - Time-out after four character times; restart at stop centre or queue read.
// RL20 - Flag break when receive line low longer than one full character.
// RL21 - Line control bit 6 forces transmit output low until cleared.
// RL22 - Shared generator: optional divide-by-4, 16-bit divisor, sample rate, 8 in 8x.
// RL23 - Divisor from two bytes, 1 to 65535; zero produces no baud ticks.
// RL24 - Highest pending priority shows; lower ones surface once higher ones clear.
package uart_support_pkg;

  localparam logic [3:0] OFS_DATA   = 4'h0;
  localparam logic [3:0] OFS_IER    = 4'h1;
  localparam logic [3:0] OFS_ISR    = 4'h2;
  localparam logic [3:0] OFS_LCR    = 4'h3;
  localparam logic [3:0] OFS_MCR    = 4'h4;
  localparam logic [3:0] OFS_LSR    = 4'h5;
  localparam logic [3:0] OFS_MSR    = 4'h6;
  localparam logic [3:0] OFS_SAMPLE = 4'h7;
  localparam logic [3:0] OFS_EFR    = 4'h8;
  localparam logic [3:0] OFS_SLEEP  = 4'h9;
  localparam logic [3:0] OFS_OPTS   = 4'hA;
  localparam logic [3:0] OFS_DIV_LO = 4'hB;
  localparam logic [3:0] OFS_DIV_HI = 4'hC;

  localparam logic [5:0] ID_NONE    = 6'h01;
  localparam logic [5:0] ID_LINE    = 6'h06;
  localparam logic [5:0] ID_RXDATA  = 6'h04;
  localparam logic [5:0] ID_TIMEOUT = 6'h0C;
  localparam logic [5:0] ID_TXROOM  = 6'h02;
  localparam logic [5:0] ID_MODEM   = 6'h00;
  localparam logic [5:0] ID_XOFF    = 6'h10;
  localparam logic [5:0] ID_FLOWPIN = 6'h20;

  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_LINE = 2;
  localparam int IER_MODEM = 3;
  localparam int IER_SLEEP = 4;
  localparam int IER_XOFF = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam int EFR_ENH = 4;
  localparam int LCR_BREAK = 6;
  localparam int MCR_PRESC = 7;
  localparam int SMP_8X = 5;
  localparam int OPT_FIFO = 0;
  localparam int OPT_AUTO485 = 1;
  localparam int OPT_AUTO_CTS = 2;
  localparam int OPT_AUTO_RTS = 3;

  localparam logic [7:0] RST_IER    = 8'h00;
  localparam logic [7:0] RST_LCR    = 8'h00;
  localparam logic [7:0] RST_MCR    = 8'h00;
  localparam logic [7:0] RST_EFR    = 8'h00;
  localparam logic [7:0] RST_SLEEP  = 8'h00;
  localparam logic [7:0] RST_SAMPLE = 8'h10;
  localparam logic [7:0] RST_OPTS   = 8'h00;
  localparam logic [7:0] RST_DIV    = 8'h00;
  localparam logic [7:0] SLEEP_KEY  = 8'hFF;
  localparam logic [4:0] RATE_8X    = 5'h08;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam int TIMEOUT_CHARS = 4;

  typedef struct packed {
    logic       empty;
    logic       above_trig;
    logic [2:0] head_err;
    logic       err_in_fifo;
    logic       overrun;
    logic       char_done;
    logic [7:0] data;
  } rx_stat_s;

  typedef struct packed {
    logic below_trig;
    logic holder_empty;
    logic tx_empty;
  } tx_stat_s;

  typedef struct packed {
    logic xoff_det;
    logic xon_det;
    logic special_det;
    logic rts_n;
  } flow_s;

  typedef enum logic [1:0] {
    AWAKE  = 2'b01,
    ASLEEP = 2'b10
  } power_e;

endpackage : uart_support_pkg

/* File: uart_support.sv */
// Interrupt, sleep, time-out, break and baud generation logic of one UART channel
`timescale 1ns/10ps
`default_nettype none
module uart_support
  import uart_support_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       ARST_N_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire rx_stat_s   RX_STAT_I,
  input  wire tx_stat_s   TX_STAT_I,
  input  wire flow_s      FLOW_I,
  input  wire logic       RXD_I,
  input  wire logic [3:0] MODEM_N_I,
  input  wire logic       TXD_I,
  output logic            TXD_O,
  output logic            RX_POP_O,
  output logic            TX_PUSH_O,
  output logic      [7:0] TX_DATA_O,
  output logic            SAMPLE_TICK_O,
  output logic            BIT_TICK_O,
  output logic            BREAK_DET_O,
  output logic            SLEEP_O,
  output logic            IRQ_O
);

  typedef struct packed {
    logic [7:0]  interrupt_enable_reg;
    logic [7:0]  line_control_reg;
    logic [7:0]  modem_control_reg;
    logic [7:0]  enhanced_feature_reg;
    logic [7:0]  sleep_key;
    logic [7:0]  smp;
    logic [7:0]  opts;
    logic [15:0] div;
    logic [7:0]  rdata;
    logic        overrun;
    logic        timeout;
    logic        txroom;
    logic        tx_cond_q;
    logic [3:0]  msr_delta;
    logic [3:0]  modem_q;
    logic        rxd_q;
    logic        xoff;
    logic        special;
    logic        flowpin;
    logic        rts_q;
    logic [1:0]  presc;
    logic [15:0] divcnt;
    logic [4:0]  smpcnt;
    logic [3:0]  brkcnt;
    logic        brk_done;
    logic [5:0]  tocnt;
    power_e      pwr;
    logic        sample_tick;
    logic        bit_tick;
    logic        brk_pulse;
    logic        txpush;
    logic [7:0]  txdata;
    logic        rxpop;
  } state_s;

  state_s st;
  state_s next_st;

  logic       wr_data;
  logic       rd_data;
  logic       rd_isr;
  logic       rd_lsr;
  logic       rd_msr;
  logic       tx_cond;
  logic       line_irq;
  logic       rx_irq;
  logic       to_irq;
  logic       tx_irq;
  logic       modem_irq;
  logic       xoff_irq;
  logic       pin_irq;
  logic [5:0] ident;
  logic [7:0] lsr_val;
  logic [7:0] msr_val;
  logic [4:0] rate;
  logic [3:0] char_bits;
  logic [5:0] to_limit;
  logic       presc_tick;
  logic       modem_chg;
  logic       rxd_chg;
  logic       sleep_ok;

  always_comb begin
    wr_data = WR_I && (ADDR_I == OFS_DATA);
    rd_data = RD_I && (ADDR_I == OFS_DATA);
    rd_isr  = RD_I && (ADDR_I == OFS_ISR);
    rd_lsr  = RD_I && (ADDR_I == OFS_LSR);
    rd_msr  = RD_I && (ADDR_I == OFS_MSR);
    // RL22 sample rate select
    rate = st.smp[SMP_8X] ? RATE_8X : st.smp[4:0];
    // Start, data bits, optional parity, one or two stop bits
    char_bits = 4'h7 + {2'h0, st.line_control_reg[1:0]} + {3'h0, st.line_control_reg[3]} + {3'h0, st.line_control_reg[2]};
    to_limit = 6'(TIMEOUT_CHARS) * {2'h0, char_bits};
    presc_tick = !st.modem_control_reg[MCR_PRESC] || (st.presc == PRESC_LAST);
    modem_chg = (MODEM_N_I != st.modem_q);
    rxd_chg = (RXD_I != st.rxd_q);
    // RL10 head status, zero when empty
    lsr_val = {RX_STAT_I.err_in_fifo, TX_STAT_I.tx_empty, TX_STAT_I.holder_empty,
               RX_STAT_I.empty ? 3'h0 : RX_STAT_I.head_err, st.overrun, !RX_STAT_I.empty};
    msr_val = {~MODEM_N_I, st.msr_delta};
    // RL5 transmit room condition by mode
    if (st.opts[OPT_AUTO485]) begin
      tx_cond = TX_STAT_I.tx_empty;
    end else if (st.opts[OPT_FIFO]) begin
      tx_cond = TX_STAT_I.below_trig;
    end else begin
      tx_cond = TX_STAT_I.holder_empty;
    end
    // RL9 line interrupt sources
    line_irq  = st.interrupt_enable_reg[IER_LINE] && (st.overrun || lsr_val[7] || (|lsr_val[4:2]));
    // RL3 receive data by level or ready
    rx_irq    = st.interrupt_enable_reg[IER_RX] && (st.opts[OPT_FIFO] ? RX_STAT_I.above_trig : !RX_STAT_I.empty);
    // RL4 stale data time-out
    to_irq    = st.interrupt_enable_reg[IER_RX] && st.timeout;
    tx_irq    = st.interrupt_enable_reg[IER_TX] && st.txroom;
    // RL6 modem status bits 0-3
    modem_irq = st.interrupt_enable_reg[IER_MODEM] && (|st.msr_delta);
    // RL7 Xoff or special character
    xoff_irq  = st.interrupt_enable_reg[IER_XOFF] && (st.xoff || st.special);
    // RL8 flow pin deassertion
    pin_irq   = (st.interrupt_enable_reg[IER_RTS] || st.interrupt_enable_reg[IER_CTS]) && st.flowpin;
    // RL24 highest priority first
    if (line_irq) begin
      // RL2 line status code
      ident = ID_LINE;
    end else if (rx_irq) begin
      ident = ID_RXDATA;
    end else if (to_irq) begin
      ident = ID_TIMEOUT;
    end else if (tx_irq) begin
      ident = ID_TXROOM;
    end else if (modem_irq) begin
      ident = ID_MODEM;
    end else if (xoff_irq) begin
      ident = ID_XOFF;
    end else if (pin_irq) begin
      ident = ID_FLOWPIN;
    end else begin
      // RL1 nothing pending
      ident = ID_NONE;
    end
    // RL16 sleep permission, RL17 entry conditions
    sleep_ok = st.enhanced_feature_reg[EFR_ENH] && st.interrupt_enable_reg[IER_SLEEP] && RXD_I && !rxd_chg && !modem_chg
               && TX_STAT_I.tx_empty && RX_STAT_I.empty && (st.sleep_key == SLEEP_KEY)
               && !(line_irq || rx_irq || to_irq || modem_irq || xoff_irq || pin_irq)
               && !WR_I;
  end

  always_comb begin
    next_st = st;
    next_st.rxd_q = RXD_I;
    next_st.modem_q = MODEM_N_I;
    next_st.tx_cond_q = tx_cond;
    next_st.rts_q = FLOW_I.rts_n;
    next_st.txpush = wr_data;
    next_st.rxpop = rd_data;
    next_st.sample_tick = 1'b0;
    next_st.bit_tick = 1'b0;
    next_st.brk_pulse = 1'b0;
    if (wr_data) begin
      next_st.txdata = WDATA_I;
    end

    if (WR_I) begin
      unique case (ADDR_I)
        OFS_IER:    next_st.interrupt_enable_reg = WDATA_I;
        OFS_LCR:    next_st.line_control_reg = WDATA_I;
        OFS_MCR:    next_st.modem_control_reg = WDATA_I;
        OFS_SAMPLE: next_st.smp = WDATA_I;
        OFS_EFR:    next_st.enhanced_feature_reg = WDATA_I;
        OFS_SLEEP:  next_st.sleep_key = WDATA_I;
        OFS_OPTS:   next_st.opts = WDATA_I;
        // RL23 divisor bytes
        OFS_DIV_LO: next_st.div[7:0] = WDATA_I;
        OFS_DIV_HI: next_st.div[15:8] = WDATA_I;
        default:    next_st.div = st.div;
      endcase
    end

    if (RD_I) begin
      unique case (ADDR_I)
        OFS_DATA:   next_st.rdata = RX_STAT_I.data;
        OFS_IER:    next_st.rdata = st.interrupt_enable_reg;
        OFS_ISR:    next_st.rdata = {2'h0, ident};
        OFS_LCR:    next_st.rdata = st.line_control_reg;
        OFS_MCR:    next_st.rdata = st.modem_control_reg;
        OFS_LSR:    next_st.rdata = lsr_val;
        OFS_MSR:    next_st.rdata = msr_val;
        OFS_SAMPLE: next_st.rdata = st.smp;
        OFS_EFR:    next_st.rdata = st.enhanced_feature_reg;
        OFS_SLEEP:  next_st.rdata = st.sleep_key;
        OFS_OPTS:   next_st.rdata = {6'h00, st.pwr == ASLEEP, st.opts[0]} | (st.opts & 8'hFE);
        OFS_DIV_LO: next_st.rdata = st.div[7:0];
        OFS_DIV_HI: next_st.rdata = st.div[15:8];
        default:    next_st.rdata = 8'h00;
      endcase
    end

    // RL11 overrun clears on line status read, a new overrun wins
    if (rd_lsr) begin
      next_st.overrun = 1'b0;
    end
    if (RX_STAT_I.overrun) begin
      next_st.overrun = 1'b1;
    end

    // RL13 transmit room clears on status read or holding write
    if (rd_isr || wr_data) begin
      next_st.txroom = 1'b0;
    end
    if (tx_cond && !st.tx_cond_q) begin
      next_st.txroom = 1'b1;
    end

    // RL13 modem and pin interrupts clear on modem read
    if (rd_msr) begin
      next_st.msr_delta = 4'h0;
      next_st.flowpin = 1'b0;
    end
    // Ring indicator reports only its trailing edge, the others any change
    next_st.msr_delta[0] = next_st.msr_delta[0] | (MODEM_N_I[0] ^ st.modem_q[0]);
    next_st.msr_delta[1] = next_st.msr_delta[1] | (MODEM_N_I[1] ^ st.modem_q[1]);
    next_st.msr_delta[2] = next_st.msr_delta[2] | (MODEM_N_I[2] & !st.modem_q[2]);
    next_st.msr_delta[3] = next_st.msr_delta[3] | (MODEM_N_I[3] ^ st.modem_q[3]);
    // RL8 low-to-high under auto flow control
    if ((st.opts[OPT_AUTO_CTS] && MODEM_N_I[0] && !st.modem_q[0])
        || (st.opts[OPT_AUTO_RTS] && FLOW_I.rts_n && !st.rts_q)) begin
      next_st.flowpin = 1'b1;
    end

    // RL14 Xoff and special character clearing
    if (FLOW_I.xon_det || rd_isr) begin
      next_st.xoff = 1'b0;
    end
    if (rd_isr || RX_STAT_I.char_done) begin
      next_st.special = 1'b0;
    end
    if (FLOW_I.xoff_det) begin
      next_st.xoff = 1'b1;
    end
    if (FLOW_I.special_det) begin
      next_st.special = 1'b1;
    end

    // RL22 prescaler and divisor; RL23 zero divisor gives no ticks
    if (st.pwr == AWAKE && st.div != 16'h0000) begin
      next_st.presc = st.modem_control_reg[MCR_PRESC] ? st.presc + 2'h1 : 2'h0;
      if (presc_tick) begin
        if (st.divcnt >= st.div - 16'h0001) begin
          next_st.divcnt = 16'h0000;
          next_st.sample_tick = 1'b1;
          if (st.smpcnt >= rate - 5'h01) begin
            next_st.smpcnt = 5'h00;
            next_st.bit_tick = 1'b1;
          end else begin
            next_st.smpcnt = st.smpcnt + 5'h01;
          end
        end else begin
          next_st.divcnt = st.divcnt + 16'h0001;
        end
      end
    end else begin
      next_st.presc = 2'h0;
      next_st.divcnt = 16'h0000;
      next_st.smpcnt = 5'h00;
    end

    // RL20 break after more than one character time low
    if (RXD_I) begin
      next_st.brkcnt = 4'h0;
      next_st.brk_done = 1'b0;
    end else if (st.bit_tick && !st.brk_done) begin
      if (st.brkcnt > char_bits) begin
        next_st.brk_pulse = 1'b1;
        next_st.brk_done = 1'b1;
      end else begin
        next_st.brkcnt = st.brkcnt + 4'h1;
      end
    end

    // RL19 time-out counter restarts at stop centre and on queue read
    if (RX_STAT_I.char_done || rd_data || RX_STAT_I.empty || RX_STAT_I.above_trig) begin
      next_st.tocnt = 6'h00;
    end else if (st.bit_tick && st.tocnt < to_limit) begin
      next_st.tocnt = st.tocnt + 6'h01;
    end
    // RL12 time-out clears on holding read; a new expiry wins
    if (rd_data) begin
      next_st.timeout = 1'b0;
    end
    if (st.bit_tick && st.tocnt == to_limit - 6'h01 && !RX_STAT_I.char_done) begin
      next_st.timeout = 1'b1;
    end

    unique case (st.pwr)
      AWAKE: begin
        if (sleep_ok) begin
          next_st.pwr = ASLEEP;
        end
      end
      ASLEEP: begin
        // RL18 wake events
        if (rxd_chg || modem_chg || wr_data || !st.interrupt_enable_reg[IER_SLEEP] || !st.enhanced_feature_reg[EFR_ENH]) begin
          next_st.pwr = AWAKE;
        end
      end
      default: next_st.pwr = AWAKE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st           <= '0;
      st.interrupt_enable_reg       <= RST_IER;
      st.line_control_reg       <= RST_LCR;
      st.modem_control_reg       <= RST_MCR;
      st.enhanced_feature_reg       <= RST_EFR;
      st.sleep_key <= RST_SLEEP;
      st.smp       <= RST_SAMPLE;
      st.opts      <= RST_OPTS;
      st.div       <= {RST_DIV, RST_DIV};
      st.rxd_q     <= 1'b1;
      st.modem_q   <= 4'hF;
      st.rts_q     <= 1'b1;
      st.pwr       <= AWAKE;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    RDATA_O = st.rdata;
    // RL21 forced break on transmit line
    TXD_O = TXD_I && !st.line_control_reg[LCR_BREAK];
    RX_POP_O = st.rxpop;
    TX_PUSH_O = st.txpush;
    TX_DATA_O = st.txdata;
    SAMPLE_TICK_O = st.sample_tick;
    BIT_TICK_O = st.bit_tick;
    BREAK_DET_O = st.brk_pulse;
    SLEEP_O = (st.pwr == ASLEEP);
    // RL15 polled mode keeps the output quiet
    IRQ_O = (ident != ID_NONE) && (|st.interrupt_enable_reg[3:0]);
  end

endmodule : uart_support
`default_nettype wire

/* File: uart_support_assertions.sv */
// Port checker of the UART support channel
`timescale 1ns/10ps
`default_nettype none
module uart_support_assertions
  import uart_support_pkg::*;
(
  input wire logic       CLK_SYS_I,
  input wire logic       ARST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire rx_stat_s   RX_STAT_I,
  input wire tx_stat_s   TX_STAT_I,
  input wire logic       RXD_I,
  input wire logic       TXD_O,
  input wire logic       TX_PUSH_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic       SAMPLE_TICK_O,
  input wire logic       SLEEP_O,
  input wire logic       IRQ_O
);
  logic [7:0] regs [16];
  logic       div_zero;
  logic       id_rd;
  // Shadow of written registers; all used ones reset to zero
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (WR_I) begin
      regs[ADDR_I] <= WDATA_I;
    end
  end
  assign div_zero = (regs[OFS_DIV_LO] == 8'h00) && (regs[OFS_DIV_HI] == 8'h00);
  assign id_rd    = RD_I && (ADDR_I == OFS_ISR);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  poll_quiet_a: assert property (
    regs[OFS_IER][3:0] == 4'h0 |-> !IRQ_O) else $error("IRQ_O high in polled mode");
  brk_force_a: assert property (
    regs[OFS_LCR][LCR_BREAK] |-> !TXD_O) else $error("TXD_O not low during break");
  push_data_a: assert property (
    WR_I && ADDR_I == OFS_DATA |=> TX_PUSH_O && TX_DATA_O == $past(WDATA_I))
    else $error("transmit write not passed on");
  line_id_a: assert property (
    id_rd && regs[OFS_IER][IER_LINE] && RX_STAT_I.err_in_fifo |=> RDATA_O == {2'b00, ID_LINE})
    else $error("line status not reported first");
  rx_id_a: assert property (
    id_rd && regs[OFS_IER][2:0] == 3'b001 && !regs[OFS_OPTS][OPT_FIFO] && !RX_STAT_I.empty
    |=> RDATA_O == {2'b00, ID_RXDATA}) else $error("receive data not reported");
  lsr_head_a: assert property (
    RD_I && ADDR_I == OFS_LSR |=> RDATA_O[4:2] == ($past(RX_STAT_I.empty) ? 3'b000 : $past(RX_STAT_I.head_err)))
    else $error("line status head bits wrong");
  div_zero_a: assert property (
    div_zero && $past(div_zero) |-> !SAMPLE_TICK_O) else $error("tick with zero divisor");
  tick_gap_a: assert property (
    SAMPLE_TICK_O && !WR_I && regs[OFS_DIV_LO] == 8'h02 && regs[OFS_DIV_HI] == 8'h00 && !regs[OFS_MCR][MCR_PRESC]
    |=> !SAMPLE_TICK_O ##1 SAMPLE_TICK_O) else $error("sample tick spacing wrong");
  sleep_guard_a: assert property (
    $rose(SLEEP_O) |-> $past(regs[OFS_EFR][EFR_ENH]) && $past(regs[OFS_IER][IER_SLEEP])
    && $past(regs[OFS_SLEEP]) == SLEEP_KEY && $past(TX_STAT_I.tx_empty) && $past(RX_STAT_I.empty))
    else $error("sleep entered without its conditions");
  wake_a: assert property (
    SLEEP_O && $changed(RXD_I) |-> ##[1:4] !SLEEP_O) else $error("no wake on receive line change");
  cover property ($rose(SLEEP_O));
  cover property (id_rd && IRQ_O);
  cover property (WR_I && regs[OFS_LCR][LCR_BREAK]);
endmodule : uart_support_assertions
bind uart_support uart_support_assertions uart_support_assertions_i (
  .CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .RX_STAT_I(RX_STAT_I), .TX_STAT_I(TX_STAT_I), .RXD_I(RXD_I),
  .TXD_O(TXD_O), .TX_PUSH_O(TX_PUSH_O), .TX_DATA_O(TX_DATA_O), .SAMPLE_TICK_O(SAMPLE_TICK_O),
  .SLEEP_O(SLEEP_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: rx_path_model.sv */
// Receive path model: character queue with per-character error bits
`timescale 1ns/10ps
`default_nettype none
module rx_path_model
  import uart_support_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic pop_i,
  output rx_stat_s  stat_o
);
  logic [10:0] q [$];
  logic [7:0]  last = 8'h00;
  task automatic refresh();
    logic e;
    e = 1'b0;
    foreach (q[i]) e |= (q[i][10:8] != 3'b000);
    stat_o.empty       = (q.size() == 0);
    stat_o.above_trig  = 1'b0;
    stat_o.overrun     = 1'b0;
    stat_o.char_done   = 1'b0;
    stat_o.err_in_fifo = e;
    stat_o.head_err    = stat_o.empty ? 3'b000 : q[0][10:8];
    // Released data shows the inverse so a stale byte never matches
    stat_o.data        = stat_o.empty ? ~last : q[0][7:0];
  endtask : refresh
  task automatic push(input logic [7:0] d, input logic [2:0] e);
    q.push_back({e, d});
    refresh();
  endtask : push
  initial begin
    refresh();
  end
  // Pops mid-cycle so the status never changes at the edge that samples it
  always @(negedge clk_i) begin
    if (pop_i && q.size() > 0) begin
      last = q[0][7:0];
      q.delete(0);
      refresh();
    end
  end
endmodule : rx_path_model
`default_nettype wire

/* File: tb.sv */
// Self-checking bench of the UART support channel
`timescale 1ns/10ps
`default_nettype none
module tb;
  import uart_support_pkg::*;
  logic       clk, arst_n, wr, rd, rxd, txd_in, txd;
  logic       rx_pop, tx_push, s_tick, b_tick, brk_det, sleep, irq;
  logic [3:0] addr, modem_n;
  logic [7:0] wdata, rdata, tx_data;
  rx_stat_s   rx_st;
  tx_stat_s   tx_st;
  flow_s      flow;
  int         errors = 0;
  int         checks = 0;
  int         cycles = 0;
  uart_support uart_support_i (
    .CLK_SYS_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RX_STAT_I(rx_st), .TX_STAT_I(tx_st), .FLOW_I(flow), .RXD_I(rxd),
    .MODEM_N_I(modem_n), .TXD_I(txd_in), .TXD_O(txd), .RX_POP_O(rx_pop), .TX_PUSH_O(tx_push),
    .TX_DATA_O(tx_data), .SAMPLE_TICK_O(s_tick), .BIT_TICK_O(b_tick), .BREAK_DET_O(brk_det),
    .SLEEP_O(sleep), .IRQ_O(irq));
  rx_path_model rx_path_model_i (.clk_i(clk), .pop_i(rx_pop), .stat_o(rx_st));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run needs about 900 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask : rd_reg
  task automatic pulse_flow(input flow_s f);
    @(posedge clk);
    flow <= f;
    @(posedge clk);
    flow <= '0;
    repeat (2) @(posedge clk);
  endtask : pulse_flow
  task automatic count(input int n, output int ns, output int nb);
    ns = 0;
    nb = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      ns += (s_tick === 1'b1);
      nb += (b_tick === 1'b1);
    end
  endtask : count
  task automatic t_reset();
    rd_reg(OFS_ISR, 8'h01, "ident idle");
    rd_reg(OFS_SAMPLE, RST_SAMPLE, "sample reset");
    chk("irq idle", {7'h00, irq}, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_line();
    wr_reg(OFS_IER, 8'h07);
    rx_path_model_i.push(8'h41, 3'b010);
    rx_path_model_i.push(8'h42, 3'b000);
    rd_reg(OFS_ISR, 8'h06, "ident line");
    chk("irq line", {7'h00, irq}, 8'h01);
    rd_reg(OFS_LSR, 8'hC9, "lsr errored head");
    rd_reg(OFS_DATA, 8'h41, "data first");
    rd_reg(OFS_ISR, 8'h04, "ident rx after errors");
    rd_reg(OFS_DATA, 8'h42, "data second");
    rd_reg(OFS_ISR, 8'h01, "ident drained");
    rd_reg(OFS_LSR, 8'h40, "lsr empty");
    $display("test line done");
  endtask : t_line
  task automatic t_tx();
    @(posedge clk);
    tx_st <= 3'b011;
    repeat (3) @(posedge clk);
    rd_reg(OFS_ISR, 8'h02, "ident tx");
    rd_reg(OFS_ISR, 8'h01, "ident tx read");
    @(posedge clk);
    tx_st <= 3'b001;
    @(posedge clk);
    tx_st <= 3'b011;
    repeat (3) @(posedge clk);
    wr_reg(OFS_DATA, 8'h5A);
    rd_reg(OFS_ISR, 8'h01, "ident tx write");
    chk("push data", tx_data, 8'h5A);
    $display("test tx done");
  endtask : t_tx
  task automatic t_modem();
    wr_reg(OFS_IER, 8'h08);
    @(posedge clk);
    modem_n <= 4'hD;
    repeat (4) @(posedge clk);
    rd_reg(OFS_ISR, 8'h00, "ident modem");
    rd_reg(OFS_MSR, 8'h22, "msr delta");
    rd_reg(OFS_ISR, 8'h01, "ident modem read");
    // Clear-to-send pin goes active then inactive under auto flow
    wr_reg(OFS_OPTS, 8'h04);
    wr_reg(OFS_IER, 8'h80);
    @(posedge clk);
    modem_n <= 4'hC;
    @(posedge clk);
    modem_n <= 4'hD;
    repeat (2) @(posedge clk);
    rd_reg(OFS_ISR, 8'h20, "ident flow pin");
    rd_reg(OFS_MSR, 8'h21, "msr cts delta");
    rd_reg(OFS_ISR, 8'h01, "ident pin read");
    $display("test modem done");
  endtask : t_modem
  task automatic t_flow();
    wr_reg(OFS_EFR, 8'h10);
    wr_reg(OFS_IER, 8'h20);
    pulse_flow(4'b1000);
    chk("irq polled", {7'h00, irq}, 8'h00);
    wr_reg(OFS_IER, 8'h21);
    chk("irq enabled", {7'h00, irq}, 8'h01);
    pulse_flow(4'b0100);
    rd_reg(OFS_ISR, 8'h01, "ident xon");
    pulse_flow(4'b0010);
    rd_reg(OFS_ISR, 8'h10, "ident special");
    rd_reg(OFS_ISR, 8'h01, "ident special read");
    pulse_flow(4'b1000);
    rd_reg(OFS_ISR, 8'h10, "ident xoff");
    rd_reg(OFS_ISR, 8'h01, "ident xoff read");
    $display("test flow done");
  endtask : t_flow
  task automatic t_baud();
    int ns;
    int nb;
    wr_reg(OFS_LCR, 8'h40);
    chk("txd break", {7'h00, txd}, 8'h00);
    wr_reg(OFS_LCR, 8'h00);
    chk("txd normal", {7'h00, txd}, 8'h01);
    wr_reg(OFS_SAMPLE, 8'h20);
    wr_reg(OFS_DIV_LO, 8'h02);
    count(16, ns, nb);
    count(80, ns, nb);
    chk("sample ticks", 8'(ns), 8'h28);
    chk("bit ticks", 8'(nb), 8'h05);
    wr_reg(OFS_MCR, 8'h80);
    count(16, ns, nb);
    count(80, ns, nb);
    chk("prescaled ticks", 8'(ns), 8'h0A);
    wr_reg(OFS_DIV_LO, 8'h00);
    count(16, ns, nb);
    count(80, ns, nb);
    chk("zero divisor", 8'(ns), 8'h00);
    wr_reg(OFS_MCR, 8'h00);
    wr_reg(OFS_DIV_LO, 8'h01);
    $display("test baud done");
  endtask : t_baud
  task automatic t_timeout();
    int nb;
    nb = 0;
    wr_reg(OFS_IER, 8'h01);
    rx_path_model_i.push(8'h33, 3'b000);
    rd_reg(OFS_ISR, 8'h04, "ident rx ready");
    wr_reg(OFS_OPTS, 8'h01);
    // Four characters of seven bits at eight samples each is 224 cycles
    repeat (170) @(posedge clk);
    rd_reg(OFS_ISR, 8'h01, "ident before timeout");
    repeat (80) @(posedge clk);
    rd_reg(OFS_ISR, 8'h0C, "ident timeout");
    rd_reg(OFS_DATA, 8'h33, "data stale");
    rd_reg(OFS_ISR, 8'h01, "ident timeout read");
    wr_reg(OFS_OPTS, 8'h00);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (200) begin
      @(posedge clk);
      #1;
      nb += (brk_det === 1'b1);
    end
    chk("break pulses", 8'(nb), 8'h01);
    rxd <= 1'b1;
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_sleep();
    wr_reg(OFS_IER, 8'h10);
    repeat (20) @(posedge clk);
    chk("sleep no key", {7'h00, sleep}, 8'h00);
    wr_reg(OFS_SLEEP, 8'hFF);
    for (int i = 0; i < 20 && sleep !== 1'b1; i++) @(posedge clk);
    #1;
    chk("sleep entered", {7'h00, sleep}, 8'h01);
    @(posedge clk);
    rxd <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("sleep woken", {7'h00, sleep}, 8'h00);
    rxd <= 1'b1;
    wr_reg(OFS_IER, 8'h00);
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    arst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    tx_st = 3'b001;
    flow = '0;
    rxd = 1'b1;
    modem_n = 4'hF;
    txd_in = 1'b1;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_line();
    t_tx();
    t_modem();
    t_flow();
    t_baud();
    t_timeout();
    t_sleep();
    conclude();
  end
endmodule : tb
`default_nettype wire
